// File: pkg/geiu_map.vh
// Register map, field positions and reset values of the external pin interrupt unit
`ifndef GEIU_MAP_VH
`define GEIU_MAP_VH
`define GEIU_ADDR_W          32
`define GEIU_OFS_FLAGS       32'h4000A814
`define GEIU_OFS_CFG_A       32'h4000A860
`define GEIU_OFS_CFG_B       32'h4000A864
`define GEIU_OFS_CFG_C       32'h4000A868
`define GEIU_OFS_CFG_D       32'h4000A86C
`define GEIU_OFS_SEL_C       32'h4000BC14
`define GEIU_OFS_SEL_D       32'h4000BC18
`define GEIU_OFS_IRQ_MASK    32'h4000BC40
`define GEIU_FILT_BIT        8
`define GEIU_MODE_HI         7
`define GEIU_MODE_LO         5
`define GEIU_SEL_W           5
`define GEIU_SEL_C_RST       5'h0F
`define GEIU_SEL_D_RST       5'h10
`define GEIU_CFG_RST         9'h000
`define GEIU_MODE_OFF        3'h0
`define GEIU_MODE_RISE       3'h1
`define GEIU_MODE_FALL       3'h2
`define GEIU_MODE_BOTH       3'h3
`define GEIU_MODE_HIGH       3'h4
`define GEIU_MODE_LOW        3'h5
`define GEIU_FILT_LEN        3
`endif

// File: rtl/geiu_filter.v
// Digital input filter: output follows input after a stable run of samples
`timescale 1ns/10ps
`include "geiu_map.vh"
module geiu_filter
(
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire enable_i,
  input  wire din_i,
  output wire dout_o
);
  reg [`GEIU_FILT_LEN-1:0] hist;
  reg                      held;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hist <= {`GEIU_FILT_LEN{1'b0}};
      held <= 1'b0;
    end
    else
    begin
      hist <= {hist[`GEIU_FILT_LEN-2:0], din_i};
      if (&hist)
        held <= 1'b1;
      else if (~|hist)
        held <= 1'b0;
    end
  end
  assign dout_o = enable_i ? held : din_i;
endmodule // geiu_filter

// File: rtl/geiu_trigger.v
// Trigger detector for one channel
`timescale 1ns/10ps
`include "geiu_map.vh"
module geiu_trigger
(
  input  wire       ref_clk_i,
  input  wire       rst_i,
  input  wire [2:0] mode_i,
  input  wire       din_i,
  output reg        hit_o
);
  reg prev;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev <= 1'b0;
    else
      prev <= din_i;
  end
  always @*
  begin
    case (mode_i)
      `GEIU_MODE_RISE: hit_o = din_i & ~prev;
      `GEIU_MODE_FALL: hit_o = ~din_i & prev;
      `GEIU_MODE_BOTH: hit_o = din_i ^ prev;
      `GEIU_MODE_HIGH: hit_o = din_i;
      `GEIU_MODE_LOW:  hit_o = ~din_i;
      default:         hit_o = 1'b0;
    endcase
  end
endmodule // geiu_trigger

// File: rtl/geiu_top.v
// External pin interrupt unit: four channels, pin selectors, pending flags
// Summary of operation
// - Channels C and D select one of 24 pins; codes 0x18-0x1F reserved.
// - Selector C resets to 0x0F (PB7), selector D to 0x10 (PC0).
// - Bit 8 of each config enables digital input filtering before detection.
// - Trigger mode bits 7:5; value 0 disables the channel.
// - Mode 1 rising, 2 falling, 3 both edges.
// - Mode 4 high level, 5 low level; 6 and 7 reserved.
// - All four config registers reset to zero.
// - Pending flags A..D at bits 0..3; write one clears, zero keeps.
`timescale 1ns/10ps
`include "geiu_map.vh"
module geiu_top
(
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [31:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [7:0]  port_a_i,
  input  wire [7:0]  port_b_i,
  input  wire [7:0]  port_c_i,
  input  wire        pin_interrupt_a_i,
  input  wire        pin_interrupt_b_i,
  output wire [3:0]  pending_o,
  output wire        irq_o
);
  // ***************************************************
  // Registers
  // ***************************************************
  reg  [8:0]             cfg [0:3];
  reg  [`GEIU_SEL_W-1:0] sel_c;
  reg  [`GEIU_SEL_W-1:0] sel_d;
  reg  [3:0]             pending;
  reg  [3:0]             irq_mask;
  wire [3:0]             raw;
  wire [3:0]             filt;
  wire [3:0]             hit;
  reg  [3:0]             next_pending;
  reg  [31:0]            next_rdata;
  integer                i;

  // Pin selector; reserved codes give a quiet low input
  function sel_pin;
    input [`GEIU_SEL_W-1:0] code;
    input [23:0]            pins;
    begin
      if (code[4:3] == 2'b11)
        sel_pin = 1'b0;
      else
        sel_pin = pins[code];
    end
  endfunction

  function hit_addr;
    input [31:0] a;
    input [31:0] ofs;
    begin
      hit_addr = (a == ofs);
    end
  endfunction

  assign raw[0] = pin_interrupt_a_i;
  assign raw[1] = pin_interrupt_b_i;
  assign raw[2] = sel_pin(sel_c, {port_c_i, port_b_i, port_a_i});
  assign raw[3] = sel_pin(sel_d, {port_c_i, port_b_i, port_a_i});

  // ***************************************************
  // Channels
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      geiu_filter u_filt
      (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .enable_i  (cfg[g][`GEIU_FILT_BIT]),
        .din_i     (raw[g]),
        .dout_o    (filt[g])
      );
      geiu_trigger u_trig
      (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .mode_i    (cfg[g][`GEIU_MODE_HI:`GEIU_MODE_LO]),
        .din_i     (filt[g]),
        .hit_o     (hit[g])
      );
    end
  endgenerate

  // ***************************************************
  // Pending flags: set wins over clear
  // ***************************************************
  always @*
  begin
    next_pending = pending;
    if (wr_i && hit_addr(addr_i, `GEIU_OFS_FLAGS))
      next_pending = next_pending & ~wdata_i[3:0];
    next_pending = next_pending | hit;
  end

  // ***************************************************
  // Register writes
  // ***************************************************
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < 4; i = i + 1)
        cfg[i] <= `GEIU_CFG_RST;
      sel_c    <= `GEIU_SEL_C_RST;
      sel_d    <= `GEIU_SEL_D_RST;
      pending  <= 4'h0;
      irq_mask <= 4'h0;
    end
    else
    begin
      pending <= next_pending;
      if (wr_i)
      begin
        if (hit_addr(addr_i, `GEIU_OFS_CFG_A))
          cfg[0] <= {wdata_i[8:5], 5'h00};
        if (hit_addr(addr_i, `GEIU_OFS_CFG_B))
          cfg[1] <= {wdata_i[8:5], 5'h00};
        if (hit_addr(addr_i, `GEIU_OFS_CFG_C))
          cfg[2] <= {wdata_i[8:5], 5'h00};
        if (hit_addr(addr_i, `GEIU_OFS_CFG_D))
          cfg[3] <= {wdata_i[8:5], 5'h00};
        if (hit_addr(addr_i, `GEIU_OFS_SEL_C))
          sel_c <= wdata_i[4:0];
        if (hit_addr(addr_i, `GEIU_OFS_SEL_D))
          sel_d <= wdata_i[4:0];
        if (hit_addr(addr_i, `GEIU_OFS_IRQ_MASK))
          irq_mask <= wdata_i[3:0];
      end
    end
  end

  // ***************************************************
  // Register reads
  // ***************************************************
  always @*
  begin
    next_rdata = 32'h00000000;
    case (addr_i)
      `GEIU_OFS_FLAGS:    next_rdata = {28'h0000000, pending};
      `GEIU_OFS_CFG_A:    next_rdata = {23'h000000, cfg[0]};
      `GEIU_OFS_CFG_B:    next_rdata = {23'h000000, cfg[1]};
      `GEIU_OFS_CFG_C:    next_rdata = {23'h000000, cfg[2]};
      `GEIU_OFS_CFG_D:    next_rdata = {23'h000000, cfg[3]};
      `GEIU_OFS_SEL_C:    next_rdata = {27'h0000000, sel_c};
      `GEIU_OFS_SEL_D:    next_rdata = {27'h0000000, sel_d};
      `GEIU_OFS_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 32'h00000000;
  end

  assign pending_o = pending;
  assign irq_o     = |(pending & irq_mask);
endmodule // geiu_top

// File: test/geiu_pins.sv
// Model of the external pins that feed the interrupt unit
`timescale 1ns/10ps
module geiu_pins
(
  input  wire        ref_clk_i,
  input  wire [25:0] want_i,
  output reg  [25:0] pins_o = 26'h0000000
);
  // Pins move only just after a clock edge, like a synchronised pad
  always @(posedge ref_clk_i)
    pins_o <= want_i;
endmodule // geiu_pins

// File: test/geiu_asserts.sv
// Port checks of the pin interrupt unit, channel A and mask
`timescale 1ns/10ps
`include "geiu_map.vh"
module geiu_checker
(
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        pin_interrupt_a_i,
  input wire [3:0]  pending_o,
  input wire        irq_o
);
  reg  [3:0] cfg;
  reg  [3:0] mask;
  wire [3:0] wl = wdata_i[3:0];
  wire       clr = wr_i && addr_i == `GEIU_OFS_FLAGS;
  wire       p = pin_interrupt_a_i;
  wire       f = pending_o[0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of filter and mode of channel A, and of the mask
  always @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      {cfg, mask} <= 8'h00;
    else if (wr_i && addr_i == `GEIU_OFS_CFG_A)
      cfg <= wdata_i[8:5];
    else if (wr_i && addr_i == `GEIU_OFS_IRQ_MASK)
      mask <= wl;
  chk_rise_sets: assert property ($rose(p) && cfg == 4'h1 |-> ##[1:2] f)
    else $error("rise");
  chk_fall_sets: assert property ($fell(p) && cfg == 4'h2 |-> ##[1:2] f)
    else $error("fall");
  chk_level_sets: assert property (p && $past(p) && cfg == 4'h4 && $stable(cfg)
    |-> ##[1:2] f) else $error("level");
  chk_off_quiet: assert property (cfg[2:0] == 3'h0 && $stable(cfg) |=> !$rose(f))
    else $error("off");
  // Pin low two samples back and flag A clear, so no filtered edge is in flight
  chk_filter_delay: assert property (cfg == 4'h9 && $stable(cfg) && $rose(p)
    && !$past(p, 2) && !f |=> !f [*2]) else $error("filter");
  chk_zero_keeps: assert property (clr
    |=> ($past(pending_o) & ~$past(wl) & ~pending_o) == 4'h0) else $error("flag lost");
  chk_flag_sticky: assert property (($past(pending_o) & ~pending_o) != 4'h0
    |-> $past(clr)) else $error("flag dropped");
  chk_irq_level: assert property (irq_o == |(pending_o & mask)) else $error("irq level");
  cover property (irq_o);
  cover property (cfg == 4'h9 && $rose(f));
  cover property ($fell(f) && $past(clr));
endmodule // geiu_checker

// File: test/geiu_top_tb.sv
// Self-checking bench of the pin interrupt unit
`timescale 1ns/10ps
`include "geiu_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
bind geiu_top geiu_checker geiu_checker_inst (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .pin_interrupt_a_i, .pending_o, .irq_o);
module geiu_top_tb;
  logic        ref_clk_i = 0;
  logic        rst_i = 1;
  logic [31:0] addr_i = 0;
  logic [31:0] wdata_i = 0;
  logic        wr_i = 0;
  logic        rd_i = 0;
  logic [25:0] want = 0;
  wire  [25:0] pins;
  wire  [31:0] rdata_o;
  wire  [3:0]  pending_o;
  wire         irq_o;
  int          err_count = 0;
  int          total_checks = 0;
  int          seed = 32'h9FAA;
  always #5 ref_clk_i = ~ref_clk_i;
  geiu_pins geiu_pins_inst (.ref_clk_i, .want_i(want), .pins_o(pins));
  geiu_top geiu_top_inst (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .port_a_i(pins[7:0]), .port_b_i(pins[15:8]), .port_c_i(pins[23:16]),
    .pin_interrupt_a_i(pins[24]), .pin_interrupt_b_i(pins[25]), .pending_o, .irq_o);
  // Truth table per mode, indexed by old and new level
  function automatic logic hit(input int m, input bit [1:0] v);
    return 1'((24'h7E6420 >> (m * 4 + v)));
  endfunction
  task automatic t(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    t(1);
    wr_i <= 0;
  endtask
  task automatic r(input logic [31:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    t(1);
    rd_i <= 0;
    `CHK("rdata", e, rdata_o)
  endtask
  task automatic run_case(input int ch, input int m);
    int     pin;
    int     code;
    bit [1:0] v;
    code = $unsigned($random(seed)) % 24;
    pin = ch < 2 ? 24 + ch : code;
    v = 2'($random(seed));
    if (ch > 1)
      w(ch == 2 ? `GEIU_OFS_SEL_C : `GEIU_OFS_SEL_D, code);
    w(`GEIU_OFS_CFG_A + 4 * ch, m << 5);
    want <= (want & ~(26'h1 << pin)) | (26'(v[1]) << pin);
    t(4);
    w(`GEIU_OFS_FLAGS, 1 << ch);
    want <= (want & ~(26'h1 << pin)) | (26'(v[0]) << pin);
    t(4);
    `CHK("pending", hit(m, v), pending_o[ch])
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 0;
    r(`GEIU_OFS_SEL_C, 32'h0000000F);
    r(`GEIU_OFS_SEL_D, 32'h00000010);
    for (int c = 0; c < 5; c++)
      r(c < 4 ? `GEIU_OFS_CFG_A + 4 * c : `GEIU_OFS_FLAGS, 32'h00000000);
    r(32'h4000A870, 32'h00000000);
    w(`GEIU_OFS_CFG_B, 32'hFFFFFFFF);
    r(`GEIU_OFS_CFG_B, 32'h000001E0);
    w(`GEIU_OFS_SEL_C, 32'h00000018);
    w(`GEIU_OFS_CFG_C, 32'h00000080);
    r(`GEIU_OFS_SEL_C, 32'h00000018);
    want <= '1;
    t(8);
    `CHK("reserved", 2'b00, pending_o[2:1])
    for (int i = 0; i < 48; i++)
      run_case($unsigned($random(seed)) % 4, i % 6);
    w(`GEIU_OFS_CFG_A, 32'h00000120);
    want[24] <= 0;
    t(6);
    w(`GEIU_OFS_FLAGS, 32'h00000001);
    want[24] <= 1;
    t(2);
    `CHK("filtered", 1'b0, pending_o[0])
    t(6);
    `CHK("filtered", 1'b1, pending_o[0])
    w(`GEIU_OFS_IRQ_MASK, 32'h00000001);
    `CHK("irq", 1'b1, irq_o)
    w(`GEIU_OFS_FLAGS, 32'h00000000);
    `CHK("kept", 1'b1, pending_o[0])
    w(`GEIU_OFS_FLAGS, 32'h0000000F);
    `CHK("cleared", 2'b00, {pending_o[0], irq_o})
    complete_run();
  end
endmodule // geiu_top_tb
